// File: design/aasc_pkg.sv
// Constants, register map and carrier types for the auxiliary converter sequencer.
// Assumes one modulator clock period per enabled sys_clk cycle.
package aasc_pkg;
    localparam int AASC_DW = 16;
    localparam int AASC_TW = 13;
    // Register map
    localparam logic [7:0] AASC_ADDR_SEQ_CFG = 8'h8C;
    localparam logic [7:0] AASC_ADDR_SCRATCH = 8'h8D;
    localparam logic [7:0] AASC_ADDR_OFFSET = 8'h8E;
    localparam logic [7:0] AASC_ADDR_GAIN = 8'h8F;
    localparam logic [15:0] AASC_RST_SEQ_CFG = 16'h0000;
    localparam logic [15:0] AASC_RST_SCRATCH = 16'h0000;
    localparam logic [15:0] AASC_RST_TRIM = 16'h0000;
    // Writable bit masks; everything else reads zero
    localparam logic [15:0] AASC_MASK_SEQ_CFG = 16'hC703;
    localparam logic [15:0] AASC_MASK_SCRATCH = 16'h00FF;
    // Field positions of the sequencer config
    localparam int AASC_MODE_HI = 15;
    localparam int AASC_MODE_LO = 14;
    localparam int AASC_DLY_HI = 10;
    localparam int AASC_DLY_LO = 8;
    localparam int AASC_OSR_HI = 1;
    localparam int AASC_OSR_LO = 0;
    // Start modes
    localparam logic [1:0] AASC_MODE_SINGLE = 2'h0;
    localparam logic [1:0] AASC_MODE_TRIG = 2'h1;
    // Settle and conversion lengths in modulator periods
    localparam logic [AASC_TW-1:0] AASC_SETTLE_CYC [0:7] = '{
        13'h0010, 13'h0040, 13'h0080, 13'h0100, 13'h0200, 13'h0400, 13'h0800, 13'h1000};
    localparam logic [AASC_TW-1:0] AASC_CONV_CYC [0:3] = '{13'h0180, 13'h0200, 13'h0300, 13'h0500};
    // Decimation: fixed third-order stage, then optional first-order averager
    localparam logic [6:0] AASC_SINC3_RATIO = 7'h40;
    localparam logic [3:0] AASC_SINC1_RATIO [0:3] = '{4'h1, 4'h2, 4'h4, 4'h8};
    // Gain code bit that selects gain 4 (codes 10 and 11)
    localparam int AASC_GAIN4_BIT = 1;
    localparam int AASC_TRIM_FRAC = 16;

    typedef enum logic [1:0] {AASC_IDLE, AASC_SETTLE, AASC_CONVERT} aasc_state_t;

    typedef struct packed {
        logic [1:0] mode;
        logic [2:0] delay;
        logic [1:0] osr;
    } aasc_cfg_t;

    typedef struct packed {
        logic [1:0] step;
        logic [AASC_DW-1:0] data;
    } aasc_result_t;
endpackage

// File: design/aasc_trim.sv
// Offset then gain correction of one raw conversion, saturating to 16 bits.
// Assumes raw words arrive as one-cycle valid pulses from the sequencer.
module aasc_trim
    import aasc_pkg::*;
(
    input wire logic sys_clk, // 200 MHz clock
    input wire logic sys_rst, // Synchronous reset
    input wire logic ce, // Clock enable
    input wire logic clear, // Zero the output data
    input wire logic raw_valid, // Raw word present
    input wire aasc_result_t raw, // Raw word and step
    input wire logic [1:0] gain_setting, // Analog gain code of the step
    input wire logic [15:0] offset_trim, // Two's-complement offset
    input wire logic [15:0] gain_trim, // Two's-complement gain
    output aasc_result_t out_ff, // Corrected word and step
    output logic out_valid_ff // Corrected word strobe
);
    // ----------------------------------------
    // Datapath
    // ----------------------------------------
    wire logic signed [17:0] off_scaled;
    wire logic signed [17:0] diff;
    wire logic signed [17:0] factor;
    wire logic signed [35:0] product;
    wire logic signed [19:0] scaled;
    wire logic [15:0] sat;

    // At gain 4 one offset step spans two result steps
    assign off_scaled = gain_setting[AASC_GAIN4_BIT] ? 18'($signed(offset_trim)) <<< 1
                                                     : 18'($signed(offset_trim));
    assign diff = 18'($signed(raw.data)) - off_scaled;
    assign factor = 18'sh10000 + 18'($signed(gain_trim));
    assign product = diff * factor;
    assign scaled = product[35:AASC_TRIM_FRAC];
    assign sat = (scaled > 20'sh07FFF) ? 16'h7FFF :
                 (scaled < -20'sh08000) ? 16'h8000 : scaled[15:0];

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            out_ff <= '0;
            out_valid_ff <= 1'b0;
        end else if (ce) begin
            out_valid_ff <= raw_valid && !clear;
            if (clear) begin
                out_ff <= '0;
            end else if (raw_valid) begin
                out_ff <= '{step: raw.step, data: sat};
            end
        end
    end

    a_trim_unity: assert property (@(posedge sys_clk) disable iff (sys_rst)
        ce && raw_valid && !clear && gain_trim == 16'h0000 && offset_trim == 16'h0000
        |=> out_ff.data == $past(raw.data))
        else $error("unity trim altered the data");
endmodule

// File: design/aasc_sequencer.sv
// Auxiliary converter sequencer: start modes, settling, conversion timing, trims.
// Assumes register port and trigger inputs synchronous to sys_clk; ce marks modulator periods.
// Functional notes
// - Single-shot mode: one pass per start bit
// - Start bit aborts and restarts in all modes
// - Triggered mode: ready falling edge starts pass
// - Ready edges ignored while sequence runs
// - Codes 10 and 11 repeat continuously
// - Wait selected settling delay before each enabled step
// - Oversampling code sets ratio and conversion time
// - Fixed sinc3 by 64, then sinc1
// - Reserved bits ignore writes, read zero
// - Eight spare bits plain read/write storage
// - Offset word signed, double step at gain 4 (codes 10 and 11)
// - Gain factor is one plus word/65536
// - Disable or standby clears data and counter
module aasc_sequencer
    import aasc_pkg::*;
#(
    parameter int STEPS = 4
)
(
    input wire logic sys_clk, // 200 MHz clock
    input wire logic sys_rst, // Synchronous reset, active high
    input wire logic ce, // Clock enable, freezes all state
    input wire logic reg_wr, // Register write strobe
    input wire logic reg_rd, // Register read strobe
    input wire logic [7:0] reg_addr, // Register address
    input wire logic [15:0] reg_wdata, // Register write data
    output logic [15:0] reg_rdata_ff, // Register read data
    input wire logic sequence_start_bit, // Start pulse from the control register
    input wire logic aux_converter_enable, // Converter enabled
    input wire logic standby, // Standby or power-down
    input wire logic primary_conversion_ready_n, // Primary converter ready, active low
    input wire logic [STEPS-1:0] step_enable, // Per-step enables
    input wire logic [1:0] aux_gain_setting, // Gain code of the current step
    input wire logic [15:0] conv_raw_data, // Raw word from the decimator
    output logic [1:0] aux_sequence_counter, // Current step
    output logic seq_busy, // Sequence running
    output logic mux_settling, // Settling delay in progress
    output logic [3:0] decim_sinc1_ratio, // Averaging ratio after sinc3
    output logic [6:0] decim_sinc3_ratio, // Fixed sinc3 ratio
    output aasc_result_t aux_result_ff, // Corrected result and step
    output logic aux_result_valid_ff // Result strobe
);
    // ----------------------------------------
    // Registers
    // ----------------------------------------
    logic [15:0] seq_cfg_ff;
    logic [15:0] scratch_ff;
    logic [15:0] offset_ff;
    logic [15:0] gain_ff;
    logic ready_prev_ff;
    aasc_state_t state_ff;
    aasc_state_t nxt_state;
    logic [1:0] step_ff;
    logic [1:0] nxt_step;
    logic [AASC_TW-1:0] timer_ff;
    logic [AASC_TW-1:0] nxt_timer;

    wire aasc_cfg_t cfg;
    wire logic run_ok;
    wire logic ready_fall;
    wire logic trig_start;
    wire logic seq_restart;
    wire logic step_done;
    wire logic last_step;
    wire logic continuous;
    wire logic raw_valid;
    wire logic [AASC_TW-1:0] settle_load;
    wire logic [AASC_TW-1:0] conv_load;
    wire logic [15:0] rd_mux;
    wire aasc_result_t raw_word;

    assign cfg = '{mode: seq_cfg_ff[AASC_MODE_HI:AASC_MODE_LO], delay: seq_cfg_ff[AASC_DLY_HI:AASC_DLY_LO],
                   osr: seq_cfg_ff[AASC_OSR_HI:AASC_OSR_LO]};

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            seq_cfg_ff <= AASC_RST_SEQ_CFG;
            scratch_ff <= AASC_RST_SCRATCH;
            offset_ff <= AASC_RST_TRIM;
            gain_ff <= AASC_RST_TRIM;
        end else if (ce && reg_wr) begin
            case (reg_addr)
                AASC_ADDR_SEQ_CFG: seq_cfg_ff <= reg_wdata & AASC_MASK_SEQ_CFG;
                AASC_ADDR_SCRATCH: scratch_ff <= reg_wdata & AASC_MASK_SCRATCH;
                AASC_ADDR_OFFSET: offset_ff <= reg_wdata;
                AASC_ADDR_GAIN: gain_ff <= reg_wdata;
                default: ;
            endcase
        end
    end

    assign rd_mux = (reg_addr == AASC_ADDR_SEQ_CFG) ? seq_cfg_ff :
                    (reg_addr == AASC_ADDR_SCRATCH) ? scratch_ff :
                    (reg_addr == AASC_ADDR_OFFSET) ? offset_ff :
                    (reg_addr == AASC_ADDR_GAIN) ? gain_ff : 16'h0000;

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            reg_rdata_ff <= 16'h0000;
        end else if (ce && reg_rd) begin
            reg_rdata_ff <= rd_mux;
        end
    end

    // ----------------------------------------
    // Start decoding
    // ----------------------------------------
    assign run_ok = aux_converter_enable && !standby;
    assign ready_fall = ready_prev_ff && !primary_conversion_ready_n;
    assign seq_busy = (state_ff != AASC_IDLE);
    assign trig_start = (cfg.mode == AASC_MODE_TRIG) && ready_fall && !seq_busy;
    assign seq_restart = run_ok && (sequence_start_bit || trig_start);
    assign continuous = cfg.mode[1];
    assign settle_load = AASC_SETTLE_CYC[cfg.delay] - 13'h0001;
    assign conv_load = AASC_CONV_CYC[cfg.osr] - 13'h0001;
    assign decim_sinc3_ratio = AASC_SINC3_RATIO;
    assign decim_sinc1_ratio = AASC_SINC1_RATIO[cfg.osr];
    assign last_step = (step_ff == 2'(STEPS - 1));
    assign step_done = ((state_ff == AASC_SETTLE) && !step_enable[step_ff])
                    || ((state_ff == AASC_CONVERT) && timer_ff == '0);
    assign raw_valid = run_ok && !seq_restart && (state_ff == AASC_CONVERT) && timer_ff == '0;
    assign aux_sequence_counter = step_ff;
    assign mux_settling = (state_ff == AASC_SETTLE);
    assign raw_word = '{step: step_ff, data: conv_raw_data};

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    always_comb begin
        nxt_state = state_ff;
        nxt_step = step_ff;
        nxt_timer = (timer_ff == '0) ? timer_ff : timer_ff - 13'h0001;
        if (!run_ok) begin
            nxt_state = AASC_IDLE;
            nxt_step = 2'h0;
            nxt_timer = '0;
        end else if (seq_restart) begin
            nxt_state = AASC_SETTLE;
            nxt_step = 2'h0;
            nxt_timer = settle_load;
        end else begin
            case (state_ff)
                AASC_IDLE: ;
                AASC_SETTLE: begin
                    if (step_enable[step_ff] && timer_ff == '0) begin
                        nxt_state = AASC_CONVERT;
                        nxt_timer = conv_load;
                    end
                end
                AASC_CONVERT: ;
                default: nxt_state = AASC_IDLE;
            endcase
            if (step_done) begin
                if (!last_step) begin
                    nxt_state = AASC_SETTLE;
                    nxt_step = step_ff + 2'h1;
                    nxt_timer = settle_load;
                end else if (continuous) begin
                    nxt_state = AASC_SETTLE;
                    nxt_step = 2'h0;
                    nxt_timer = settle_load;
                end else begin
                    nxt_state = AASC_IDLE;
                    nxt_step = 2'h0;
                end
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            state_ff <= AASC_IDLE;
            step_ff <= 2'h0;
            timer_ff <= '0;
            ready_prev_ff <= 1'b1;
        end else if (ce) begin
            state_ff <= nxt_state;
            step_ff <= nxt_step;
            timer_ff <= nxt_timer;
            ready_prev_ff <= primary_conversion_ready_n;
        end
    end

    aasc_trim aasc_trim_i (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .ce(ce),
        .clear(!run_ok),
        .raw_valid(raw_valid),
        .raw(raw_word),
        .gain_setting(aux_gain_setting),
        .offset_trim(offset_ff),
        .gain_trim(gain_ff),
        .out_ff(aux_result_ff),
        .out_valid_ff(aux_result_valid_ff)
    );

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    a_start_restart: assert property (@(posedge sys_clk) disable iff (sys_rst)
        ce && run_ok && sequence_start_bit |=> state_ff == AASC_SETTLE && step_ff == 2'h0
        && timer_ff == $past(settle_load))
        else $error("start bit did not restart the sequence");
    a_trig_start: assert property (@(posedge sys_clk) disable iff (sys_rst)
        ce && run_ok && cfg.mode == AASC_MODE_TRIG && !seq_busy && ready_fall
        |=> state_ff == AASC_SETTLE && step_ff == 2'h0)
        else $error("ready edge did not start the sequence");
    a_trig_ignored: assert property (@(posedge sys_clk) disable iff (sys_rst)
        ce && run_ok && seq_busy && ready_fall && !sequence_start_bit && !step_done && timer_ff != '0
        |=> state_ff == $past(state_ff) && step_ff == $past(step_ff) && timer_ff == $past(timer_ff) - 13'h0001)
        else $error("ready edge disturbed a running sequence");
    a_single_stop: assert property (@(posedge sys_clk) disable iff (sys_rst)
        ce && run_ok && !seq_restart && step_done && last_step && !continuous |=> state_ff == AASC_IDLE)
        else $error("single-shot sequence did not stop");
    a_cont_repeat: assert property (@(posedge sys_clk) disable iff (sys_rst)
        ce && run_ok && !seq_restart && step_done && last_step && continuous
        |=> state_ff == AASC_SETTLE && step_ff == 2'h0)
        else $error("continuous sequence did not repeat");
    a_settle_len: assert property (@(posedge sys_clk) disable iff (sys_rst)
        ce && run_ok && !seq_restart && state_ff == AASC_SETTLE && step_enable[step_ff] && timer_ff != '0
        |=> state_ff == AASC_SETTLE)
        else $error("settling cut short");
    a_conv_len: assert property (@(posedge sys_clk) disable iff (sys_rst)
        ce && run_ok && !seq_restart && state_ff == AASC_SETTLE && !step_done && nxt_state == AASC_CONVERT
        |=> timer_ff == $past(conv_load))
        else $error("conversion time wrong");
    a_cfg_reserved: assert property (@(posedge sys_clk) disable iff (sys_rst)
        ce && reg_rd && reg_addr == AASC_ADDR_SEQ_CFG |=> (reg_rdata_ff & ~AASC_MASK_SEQ_CFG) == 16'h0000)
        else $error("reserved config bits not zero");
    a_disable_clear: assert property (@(posedge sys_clk) disable iff (sys_rst)
        ce && !run_ok |=> state_ff == AASC_IDLE && step_ff == 2'h0 ##1 aux_result_ff.data == 16'h0000)
        else $error("disable did not clear counter and data");
endmodule

// File: sim/aasc_sequencer_tb.sv
// Self-checking bench for the auxiliary converter sequencer.
// Holds ce high except for a 50-cycle freeze in t_steps, so other clock cycles are each one modulator period.
module aasc_sequencer_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import aasc_pkg::*;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic ce = 1'b1;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic [15:0] reg_rdata_ff;
    logic sequence_start_bit = 1'b0;
    logic aux_converter_enable = 1'b0;
    logic standby = 1'b0;
    logic primary_conversion_ready_n = 1'b1;
    logic [3:0] step_enable = 4'h1;
    logic [1:0] aux_gain_setting = 2'h0;
    logic [15:0] conv_raw_data = 16'h0000;
    logic [1:0] aux_sequence_counter;
    logic seq_busy;
    logic mux_settling;
    logic [3:0] decim_sinc1_ratio;
    logic [6:0] decim_sinc3_ratio;
    aasc_result_t aux_result_ff;
    logic aux_result_valid_ff;
    int err_count = 0;
    int comparisons = 0;
    int sett[8] = '{16, 64, 128, 256, 512, 1024, 2048, 4096};
    int conv[4] = '{384, 512, 768, 1280};

    always #2.5 sys_clk = ~sys_clk;

    aasc_sequencer #(.STEPS(4)) aasc_sequencer_i (.sys_clk(sys_clk), .sys_rst(sys_rst), .ce(ce),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata_ff(reg_rdata_ff), .sequence_start_bit(sequence_start_bit),
        .aux_converter_enable(aux_converter_enable), .standby(standby),
        .primary_conversion_ready_n(primary_conversion_ready_n), .step_enable(step_enable),
        .aux_gain_setting(aux_gain_setting), .conv_raw_data(conv_raw_data),
        .aux_sequence_counter(aux_sequence_counter), .seq_busy(seq_busy), .mux_settling(mux_settling),
        .decim_sinc1_ratio(decim_sinc1_ratio), .decim_sinc3_ratio(decim_sinc3_ratio),
        .aux_result_ff(aux_result_ff), .aux_result_valid_ff(aux_result_valid_ff));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop;
        $display("Comparisons %0d, mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(negedge sys_clk);
        reg_wr = 1'b1; reg_addr = a; reg_wdata = d;
        @(negedge sys_clk);
        reg_wr = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        @(negedge sys_clk);
        reg_rd = 1'b1; reg_addr = a;
        @(negedge sys_clk);
        reg_rd = 1'b0;
        chk(reg_rdata_ff, exp);
    endtask

    // Configuration is only changed while the converter is disabled
    task automatic cfg(input logic [1:0] m, input logic [2:0] d, input logic [1:0] o,
                       input logic [15:0] off, input logic [15:0] gn);
        @(negedge sys_clk);
        aux_converter_enable = 1'b0;
        wr(AASC_ADDR_SEQ_CFG, {m, 3'h0, d, 6'h00, o});
        wr(AASC_ADDR_OFFSET, off);
        wr(AASC_ADDR_GAIN, gn);
        aux_converter_enable = 1'b1;
    endtask

    task automatic go;
        @(negedge sys_clk);
        sequence_start_bit = 1'b1;
        @(negedge sys_clk);
        sequence_start_bit = 1'b0;
    endtask

    task automatic waitv(inout int n);
        while (aux_result_valid_ff !== 1'b1 && n < 6000) begin
            @(negedge sys_clk);
            n++;
        end
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_regs;
        rd(AASC_ADDR_SEQ_CFG, 16'h0000);
        rd(AASC_ADDR_SCRATCH, 16'h0000);
        rd(AASC_ADDR_OFFSET, 16'h0000);
        rd(AASC_ADDR_GAIN, 16'h0000);
        wr(AASC_ADDR_SEQ_CFG, 16'hFFFF);
        rd(AASC_ADDR_SEQ_CFG, 16'hC703);
        wr(AASC_ADDR_SCRATCH, 16'hFFFF);
        rd(AASC_ADDR_SCRATCH, 16'h00FF);
        wr(AASC_ADDR_SCRATCH, 16'h005A);
        rd(AASC_ADDR_SCRATCH, 16'h005A);
        wr(AASC_ADDR_OFFSET, 16'hA5C3);
        rd(AASC_ADDR_OFFSET, 16'hA5C3);
        wr(AASC_ADDR_GAIN, 16'h5A3C);
        rd(AASC_ADDR_GAIN, 16'h5A3C);
        wr(8'h80, 16'hFFFF);
        rd(8'h80, 16'h0000);
        for (int o = 0; o < 4; o++) begin
            wr(AASC_ADDR_SEQ_CFG, 16'(o));
            @(negedge sys_clk);
            chk(decim_sinc1_ratio, 32'(1 << o));
            chk(decim_sinc3_ratio, 32'd64);
        end
    endtask

    task automatic tcase(input logic [2:0] d, input logic [1:0] o, input logic [15:0] raw,
                         input logic [15:0] off, input logic [15:0] gn, input logic [15:0] exp_d);
        int n;
        cfg(2'h0, d, o, off, gn);
        conv_raw_data = raw;
        go;
        n = 1;
        waitv(n);
        chk(n, 1 + sett[d] + conv[o]);
        chk(aux_result_ff, {14'h0, 2'h0, exp_d});
        repeat (10) @(negedge sys_clk);
        chk(seq_busy, 1'b0);
    endtask

    task automatic t_cont(input logic [1:0] m, input logic use_stby);
        int n;
        cfg(m, 3'h0, 2'h0, 16'h0000, 16'h0000);
        conv_raw_data = 16'h0123;
        go;
        n = 1;
        waitv(n);
        @(negedge sys_clk);
        n = 0;
        waitv(n);
        // Period is settle, convert and three one-cycle skips; the count starts a cycle late
        chk(n, sett[0] + conv[0] + 3 - 1);
        @(negedge sys_clk);
        if (use_stby) standby = 1'b1;
        else aux_converter_enable = 1'b0;
        repeat (3) @(negedge sys_clk);
        chk(aux_sequence_counter, 2'h0);
        chk(seq_busy, 1'b0);
        chk(aux_result_ff.data, 16'h0000);
        standby = 1'b0;
    endtask

    task automatic t_trig;
        int n;
        cfg(2'h1, 3'h0, 2'h0, 16'h0000, 16'h0000);
        @(negedge sys_clk);
        primary_conversion_ready_n = 1'b0;
        @(negedge sys_clk);
        n = 1;
        repeat (99) @(negedge sys_clk);
        primary_conversion_ready_n = 1'b1;
        @(negedge sys_clk);
        primary_conversion_ready_n = 1'b0;
        n = 101;
        waitv(n);
        chk(n, 401);
        repeat (10) @(negedge sys_clk);
        primary_conversion_ready_n = 1'b1;
        @(negedge sys_clk);
        primary_conversion_ready_n = 1'b0;
        @(negedge sys_clk);
        chk(seq_busy, 1'b1);
    endtask

    // All steps enabled, with a clock-enable freeze during the first settle
    task automatic t_steps;
        int n;
        aux_converter_enable = 1'b0;
        step_enable = 4'hF;
        cfg(2'h0, 3'h0, 2'h0, 16'h0000, 16'h0000);
        conv_raw_data = 16'h0040;
        go;
        chk(mux_settling, 1'b1);
        ce = 1'b0;
        repeat (50) @(negedge sys_clk);
        chk(mux_settling, 1'b1);
        ce = 1'b1;
        n = 51;
        waitv(n);
        chk(n, 51 + sett[0] + conv[0]);
        for (int k = 0; k < 4; k++) begin
            if (k > 0) begin
                @(negedge sys_clk);
                n = 1;
                waitv(n);
                chk(n, sett[0] + conv[0]);
            end
            chk(aux_result_ff.step, k);
            chk(aux_sequence_counter, (k + 1) % 4);
        end
        repeat (5) @(negedge sys_clk);
        chk(seq_busy, 1'b0);
        aux_converter_enable = 1'b0;
        step_enable = 4'h1;
    endtask

    task automatic t_abort;
        int n;
        cfg(2'h0, 3'h0, 2'h0, 16'h0000, 16'h0000);
        go;
        repeat (199) @(negedge sys_clk);
        go;
        n = 1;
        waitv(n);
        chk(n, 401);
        repeat (10) @(negedge sys_clk);
        primary_conversion_ready_n = 1'b1;
        @(negedge sys_clk);
        primary_conversion_ready_n = 1'b0;
        repeat (2) @(negedge sys_clk);
        chk(seq_busy, 1'b0);
    endtask

    // ------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        repeat (10) @(negedge sys_clk);
        sys_rst = 1'b0;
        t_regs();
        tcase(3'h0, 2'h0, 16'h0100, 16'h0000, 16'h0000, 16'h0100);
        tcase(3'h3, 2'h1, 16'h0100, 16'h0010, 16'h0000, 16'h00F0);
        tcase(3'h7, 2'h3, 16'h0100, 16'h0010, 16'h8000, 16'h0078);
        tcase(3'h5, 2'h2, 16'h7FFF, 16'hFFFF, 16'h7FFF, 16'h7FFF);
        tcase(3'h1, 2'h0, 16'h8000, 16'h0001, 16'h0000, 16'h8000);
        aux_converter_enable = 1'b0;
        aux_gain_setting = 2'h1;
        tcase(3'h0, 2'h0, 16'h0100, 16'h0010, 16'h0000, 16'h00F0);
        aux_converter_enable = 1'b0;
        aux_gain_setting = 2'h2;
        tcase(3'h0, 2'h0, 16'h0100, 16'h0010, 16'h0000, 16'h00E0);
        aux_converter_enable = 1'b0;
        aux_gain_setting = 2'h0;
        t_cont(2'h2, 1'b0);
        t_cont(2'h3, 1'b1);
        t_trig();
        t_steps();
        t_abort();
        report_and_stop();
    end

    initial begin
        #200000;
        err_count++;
        report_and_stop();
    end
endmodule
